// ==== rtl/intc_map.svh ====
// Notes on behaviour
// - Lower vector number wins; bus reset highest, two-wire serial lowest.
// - After reset, fetch starts at 0x0000; each vector slot is two bytes.
// - Bus reset at 0x0002, 128 us timer 0x0004, 1.024 ms timer 0x0006.
// - Endpoints 0..4 use slots 0x0008..0x0010; slot 0x0012 never generated.
// - Entry waits for instruction end, then 10-cycle call, 5-cycle jump.
// - SE0 recognised as bus reset after 12 us, always before 16 us.
// - Recognised bus reset sets status bit 5; interrupt at SE0 end; aborts start-up.
// - Bus reset clears the device address registers at 0x10 and 0x40.
// - Endpoint interrupt on host ack of IN or device ack of OUT only.
// - Analog pins interrupt on polarity-selected edge, sharing vector 0x0014.
// - One triggered analog pin blocks others until inactive or disabled.
// - Pin-port pins interrupt on per-port polarity edge, sharing vector 0x0016.
// - One triggered port pin blocks others until inactive or disabled.
// - Enabled parallel host port owns the pin vector; pin interrupts suppressed.
// - Parallel host port interrupt gated only by global enable bit 5.
// - Slave receive interrupts per byte; address flag on first byte after start.
// - Slave receive stop sets stop flag and interrupts, unless last byte nacked.
// - Slave transmit interrupts per byte, acknowledge flag shows master ack.
// - Master modes interrupt per byte; clearing role bit issues stop.
// - Lost arbitration clears role, sets flag, interrupts at next stop.
// - Busy bit clears before events 1 to 4; firmware writes once to continue.
// - Each source has a sticky pending flag, requesting only when enabled.
// - Service clears core enable and its pending flag, pushes PC and flags.
// - Global enable bits 0,1,2,4,5,6 gate sources; one enables.
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH
`define CLK_PERIOD_NS 10
`define SE0_MIN_NS 12000
`define SE0_CYC ((`SE0_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SE0_CW 11
`define CALL_CYC 4'ha
`define JUMP_CYC 4'h5
`define RESET_VEC 14'h0000
`define SRC_BUSRST 0
`define SRC_T128 1
`define SRC_T1024 2
`define SRC_EP0 3
`define SRC_RSVD 8
`define SRC_ANALOG 9
`define SRC_PINS 10
`define SRC_SERIAL 11
`define GE_BUSRST 0
`define GE_T128 1
`define GE_T1024 2
`define GE_ANALOG 4
`define GE_PINS 5
`define GE_SERIAL 6
`endif

// ==== rtl/intc_pkg.sv ====
`include "intc_map.svh"
package intc_pkg;
    typedef enum logic [1:0] {IDLE = 2'h0, CALL = 2'h1, JUMP = 2'h3} entry_t;
    typedef struct packed {
        logic dp_s1, dp_s2, dm_s1, dm_s2;
        logic [7:0] an_s1, an_s2, an_prev, an_latch;
        logic [15:0] gp_s1, gp_s2, gp_prev, gp_latch;
        logic [`SE0_CW-1:0] se0_cnt;
        logic se0_seen;
        logic [11:0] pend;
        entry_t st;
        logic [3:0] cnt, sel;
        logic [13:0] vec;
        logic gie_clr, push, svc_start, rst_fetch;
        logic stat_busrst, addr_clr, start_abort;
        logic role, busy, addr_f, stop_f, ack_f, arb_f, arb_wait, rx_last, stop_req;
    } state_t;
endpackage

// ==== rtl/mcu_interrupt_controller.sv ====
`timescale 1ns/1ns
`include "intc_map.svh"
module mcu_interrupt_controller (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic d_plus,
    input wire logic d_minus,
    input wire logic timer_128us_tick,
    input wire logic timer_1024us_tick,
    input wire logic [4:0] ep_in_host_ack,
    input wire logic [4:0] ep_out_dev_ack,
    input wire logic [7:0] analog_pins,
    input wire logic [7:0] analog_polarity,
    input wire logic [7:0] analog_enable,
    input wire logic [15:0] port_pins,
    input wire logic [1:0] port_polarity,
    input wire logic [15:0] port_enable,
    input wire logic parallel_host_port_en,
    input wire logic parallel_host_port_event,
    input wire logic [7:0] global_enable,
    input wire logic [4:0] ep_enable,
    input wire logic core_gie,
    input wire logic instr_done,
    input wire logic status_busrst_clear,
    input wire logic tw_rx_byte,
    input wire logic tw_rx_first,
    input wire logic tw_tx_byte,
    input wire logic tw_tx_acked,
    input wire logic tw_master_byte,
    input wire logic tw_stop_seen,
    input wire logic tw_arb_lost,
    input wire logic fw_ctl_write,
    input wire logic fw_continue,
    input wire logic fw_role,
    input wire logic fw_ack,
    output logic [13:0] vector_addr,
    output logic fetch_from_reset,
    output logic gie_clear,
    output logic stack_push,
    output logic service_start,
    output logic status_busrst,
    output logic usb_addr_clear,
    output logic startup_abort,
    output logic [11:0] pending,
    output logic controller_role_bit,
    output logic continue_busy,
    output logic addr_flag,
    output logic rx_stop_flag,
    output logic ack_flag,
    output logic arbitration_lost_flag,
    output logic stop_request
);
    intc_pkg::state_t s_reg, s_next;

    // Edge scan shared by the analog and pin ports; a kept latch blocks all others
    function automatic logic [16:0] pin_scan(input logic [15:0] act, prv, en, lat);
        logic [15:0] keep;
        logic [15:0] hit;
        keep = lat & act & en;
        hit = act & ~prv & en;
        if (|keep)
            pin_scan = {1'b0, keep};
        else
            pin_scan = {|hit, hit};
    endfunction

    // Lowest set index wins
    function automatic logic [3:0] prio_pick(input logic [11:0] req);
        prio_pick = 4'h0;
        for (int i = 11; i >= 0; i--)
            if (req[i])
                prio_pick = 4'(i);
    endfunction

    logic se0;
    logic [7:0] an_act, an_pact;
    logic [15:0] gp_pol, gp_act, gp_pact;
    logic [16:0] an_scan, gp_scan;
    logic [11:0] en_mask, set_v, req;
    logic tw_int, stop_ok;

    // Source conditions from synchronised pins
    always_comb
    begin
        se0 = !s_reg.dp_s2 && !s_reg.dm_s2;
        an_act = ~(s_reg.an_s2 ^ analog_polarity);
        an_pact = ~(s_reg.an_prev ^ analog_polarity);
        gp_pol = {{8{port_polarity[1]}}, {8{port_polarity[0]}}};
        gp_act = ~(s_reg.gp_s2 ^ gp_pol);
        gp_pact = ~(s_reg.gp_prev ^ gp_pol);
        an_scan = pin_scan({8'h00, an_act}, {8'h00, an_pact}, {8'h00, analog_enable},
            {8'h00, s_reg.an_latch});
        gp_scan = pin_scan(gp_act, gp_pact, port_enable, s_reg.gp_latch);
        stop_ok = tw_stop_seen && !(s_reg.rx_last && !s_reg.ack_f);
        tw_int = tw_rx_byte || tw_tx_byte || tw_master_byte || (stop_ok && !s_reg.arb_wait);
    end

    // Enables per source; slot 8 stays disabled
    always_comb
    begin
        en_mask = 12'h000;
        en_mask[`SRC_BUSRST] = global_enable[`GE_BUSRST];
        en_mask[`SRC_T128] = global_enable[`GE_T128];
        en_mask[`SRC_T1024] = global_enable[`GE_T1024];
        en_mask[7:3] = ep_enable;
        en_mask[`SRC_ANALOG] = global_enable[`GE_ANALOG];
        en_mask[`SRC_PINS] = global_enable[`GE_PINS];
        en_mask[`SRC_SERIAL] = global_enable[`GE_SERIAL];
        req = s_reg.pend & en_mask;
    end

    // Events that set pending flags this cycle
    always_comb
    begin
        set_v = 12'h000;
        set_v[`SRC_BUSRST] = s_reg.se0_seen && !se0;
        set_v[`SRC_T128] = timer_128us_tick;
        set_v[`SRC_T1024] = timer_1024us_tick;
        set_v[7:3] = ep_in_host_ack | ep_out_dev_ack;
        set_v[`SRC_ANALOG] = an_scan[16];
        if (parallel_host_port_en)
            set_v[`SRC_PINS] = parallel_host_port_event;
        else
            set_v[`SRC_PINS] = gp_scan[16];
        set_v[`SRC_SERIAL] = tw_int || (s_reg.arb_wait && tw_stop_seen);
    end

    // Whole next state
    always_comb
    begin
        s_next = s_reg;
        s_next.dp_s1 = d_plus;
        s_next.dp_s2 = s_reg.dp_s1;
        s_next.dm_s1 = d_minus;
        s_next.dm_s2 = s_reg.dm_s1;
        s_next.an_s1 = analog_pins;
        s_next.an_s2 = s_reg.an_s1;
        s_next.an_prev = s_reg.an_s2;
        s_next.gp_s1 = port_pins;
        s_next.gp_s2 = s_reg.gp_s1;
        s_next.gp_prev = s_reg.gp_s2;
        s_next.an_latch = an_scan[7:0];
        // Port latch is dropped while the parallel port owns the vector
        s_next.gp_latch = parallel_host_port_en ? 16'h0000 : gp_scan[15:0];
        s_next.gie_clr = 1'b0;
        s_next.push = 1'b0;
        s_next.svc_start = 1'b0;
        s_next.rst_fetch = 1'b0;
        s_next.addr_clr = 1'b0;
        s_next.start_abort = 1'b0;
        s_next.stop_req = 1'b0;

        // SE0 timer; counter saturates so a long reset stays recognised
        if (!se0)
        begin
            s_next.se0_cnt = '0;
            s_next.se0_seen = 1'b0;
        end
        else if (s_reg.se0_cnt != `SE0_CW'(`SE0_CYC))
            s_next.se0_cnt = s_reg.se0_cnt + `SE0_CW'(1);
        else if (!s_reg.se0_seen)
        begin
            s_next.se0_seen = 1'b1;
            s_next.addr_clr = 1'b1;
            s_next.start_abort = 1'b1;
        end
        if (se0 && s_reg.se0_cnt == `SE0_CW'(`SE0_CYC) && !s_reg.se0_seen)
            s_next.stat_busrst = 1'b1;
        else if (status_busrst_clear)
            s_next.stat_busrst = 1'b0;

        // Entry sequencer; pend clear first so a same-cycle set wins
        case (s_reg.st)
            intc_pkg::IDLE:
            begin
                if (instr_done && core_gie && |req)
                begin
                    s_next.sel = prio_pick(req);
                    s_next.pend[prio_pick(req)] = 1'b0;
                    s_next.vec = {9'h000, prio_pick(req) + 4'h1, 1'b0};
                    s_next.gie_clr = 1'b1;
                    s_next.push = 1'b1;
                    // Full call length here: the first call cycle is the one that shows gie_clear
                    s_next.cnt = `CALL_CYC;
                    s_next.st = intc_pkg::CALL;
                end
            end
            intc_pkg::CALL:
            begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1)
                begin
                    s_next.cnt = `JUMP_CYC;
                    s_next.st = intc_pkg::JUMP;
                end
            end
            intc_pkg::JUMP:
            begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1)
                begin
                    s_next.svc_start = 1'b1;
                    s_next.st = intc_pkg::IDLE;
                end
            end
            default:
                s_next.st = intc_pkg::IDLE;
        endcase
        s_next.pend = s_next.pend | (set_v & 12'heff);

        // Two-wire control and flags; hardware event beats firmware write
        if (fw_ctl_write)
        begin
            s_next.busy = fw_continue;
            s_next.role = fw_role;
            s_next.ack_f = fw_ack;
            s_next.arb_f = 1'b0;
            s_next.addr_f = 1'b0;
            s_next.stop_f = 1'b0;
            if (s_reg.role && !fw_role)
                s_next.stop_req = 1'b1;
        end
        if (tw_rx_byte)
        begin
            s_next.addr_f = tw_rx_first;
            s_next.rx_last = 1'b1;
        end
        if (tw_tx_byte)
        begin
            s_next.ack_f = tw_tx_acked;
            s_next.rx_last = 1'b0;
        end
        if (tw_master_byte)
            s_next.rx_last = 1'b0;
        if (stop_ok && !s_reg.arb_wait)
        begin
            s_next.stop_f = 1'b1;
            s_next.rx_last = 1'b0;
        end
        if (tw_int)
            s_next.busy = 1'b0;
        if (tw_arb_lost)
        begin
            s_next.role = 1'b0;
            s_next.arb_f = 1'b1;
            s_next.arb_wait = 1'b1;
        end
        else if (s_reg.arb_wait && tw_stop_seen)
            s_next.arb_wait = 1'b0;
    end

    // State register with synchronous reset
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.st <= intc_pkg::IDLE;
            s_reg.vec <= `RESET_VEC;
            s_reg.rst_fetch <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    // Outputs straight from the state flops
    assign vector_addr = s_reg.vec;
    assign fetch_from_reset = s_reg.rst_fetch;
    assign gie_clear = s_reg.gie_clr;
    assign stack_push = s_reg.push;
    assign service_start = s_reg.svc_start;
    assign status_busrst = s_reg.stat_busrst;
    assign usb_addr_clear = s_reg.addr_clr;
    assign startup_abort = s_reg.start_abort;
    assign pending = s_reg.pend;
    assign controller_role_bit = s_reg.role;
    assign continue_busy = s_reg.busy;
    assign addr_flag = s_reg.addr_f;
    assign rx_stop_flag = s_reg.stop_f;
    assign ack_flag = s_reg.ack_f;
    assign arbitration_lost_flag = s_reg.arb_f;
    assign stop_request = s_reg.stop_req;

    // Checks on the sequencer and sources
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_reset_vector: assert property ($rose(rst_n) |-> fetch_from_reset && vector_addr == 14'h0000)
        else $error("reset fetch not at zero");
    chk_prio_pick: assert property (gie_clear |-> $past(req) == 12'h000 ||
        ($past(req) & ((12'h001 << s_reg.sel) - 12'h001)) == 12'h000)
        else $error("lower priority served first");
    chk_vector_slot: assert property (gie_clear |-> vector_addr[0] == 1'b0 &&
        vector_addr != 14'h0012 && vector_addr >= 14'h0002 && vector_addr <= 14'h0018)
        else $error("bad vector address");
    chk_entry_len: assert property (gie_clear |=> !service_start[*8] ##1
        !service_start[*6] ##1 service_start)
        else $error("entry latency not 15 cycles");
    chk_busrst_end: assert property ($rose(s_reg.pend[0]) |-> $past(s_reg.se0_seen))
        else $error("bus reset interrupt without reset");
    chk_addr_clear: assert property (usb_addr_clear |-> status_busrst && startup_abort)
        else $error("address clear without bus reset");
    chk_host_owns: assert property (parallel_host_port_en && !parallel_host_port_event
        |=> !$rose(s_reg.pend[10]))
        else $error("pin interrupt while host port on");
    chk_busy_clear: assert property (tw_int |=> !continue_busy)
        else $error("busy not cleared at event");
    chk_arb_lost: assert property (tw_arb_lost |=> !controller_role_bit &&
        arbitration_lost_flag)
        else $error("arbitration loss not flagged");
    chk_stop_issue: assert property (fw_ctl_write && controller_role_bit && !fw_role
        |=> stop_request)
        else $error("no stop on role clear");

    cov_nested_pick: cover property (gie_clear && $countones($past(req)) > 1);
    cov_busrst_entry: cover property (gie_clear && vector_addr == 14'h0002);
    cov_arb_then_int: cover property (tw_arb_lost ##[1:50] $rose(s_reg.pend[11]));
endmodule

// ==== bench/core_model.sv ====
`timescale 1ns/1ns
module core_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic gie_clear,
    input wire logic service_start,
    output logic instr_done,
    output logic core_gie
);
    logic [2:0] left_reg;
    logic entry_reg;

    // Instructions last 1..5 cycles; each one re-enables, as the routine's final EI would
    always @(posedge clock)
    begin
        instr_done <= 1'b0;
        if (!rst_n)
        begin
            core_gie <= 1'b0;
            left_reg <= 3'h1;
            entry_reg <= 1'b0;
        end
        else if (gie_clear)
        begin
            core_gie <= 1'b0;
            entry_reg <= 1'b1;
        end
        else if (service_start)
            entry_reg <= 1'b0;
        else if (run && !entry_reg)
        begin
            // No boundary while a call is under way: the core is busy with it
            left_reg <= left_reg - 3'h1;
            if (left_reg == 3'h1)
            begin
                instr_done <= 1'b1;
                core_gie <= 1'b1;
                left_reg <= 3'($urandom_range(5, 1));
            end
        end
    end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic clock, rst_n, d_plus, d_minus, timer_128us_tick, timer_1024us_tick, run;
    logic [4:0] ep_in_host_ack, ep_out_dev_ack, ep_enable;
    logic [7:0] analog_pins, analog_polarity, analog_enable, global_enable;
    logic [15:0] port_pins, port_enable;
    logic [1:0] port_polarity;
    logic parallel_host_port_en, parallel_host_port_event, core_gie, instr_done;
    logic status_busrst_clear, tw_rx_byte, tw_rx_first, tw_tx_byte, tw_tx_acked;
    logic tw_master_byte, tw_stop_seen, tw_arb_lost, fw_ctl_write, fw_continue, fw_role, fw_ack;
    logic [13:0] vector_addr;
    logic [11:0] pending;
    logic fetch_from_reset, gie_clear, stack_push, service_start, status_busrst;
    logic usb_addr_clear, startup_abort, controller_role_bit, continue_busy, addr_flag;
    logic rx_stop_flag, ack_flag, arbitration_lost_flag, stop_request, saw_clr;
    logic [13:0] exp_q[$];
    int n_errors, check_count, lat;

    mcu_interrupt_controller i_dut (.clock, .rst_n, .d_plus, .d_minus, .timer_128us_tick,
        .timer_1024us_tick, .ep_in_host_ack, .ep_out_dev_ack, .analog_pins, .analog_polarity,
        .analog_enable, .port_pins, .port_polarity, .port_enable, .parallel_host_port_en,
        .parallel_host_port_event, .global_enable, .ep_enable, .core_gie, .instr_done,
        .status_busrst_clear, .tw_rx_byte, .tw_rx_first, .tw_tx_byte, .tw_tx_acked,
        .tw_master_byte, .tw_stop_seen, .tw_arb_lost, .fw_ctl_write, .fw_continue, .fw_role,
        .fw_ack, .vector_addr, .fetch_from_reset, .gie_clear, .stack_push, .service_start,
        .status_busrst, .usb_addr_clear, .startup_abort, .pending, .controller_role_bit,
        .continue_busy, .addr_flag, .rx_stop_flag, .ack_flag, .arbitration_lost_flag,
        .stop_request);
    core_model i_core (.clock, .rst_n, .run, .gie_clear, .service_start, .instr_done, .core_gie);

    // Free-running 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chkb(input string what, input logic e, input logic g);
        chk(what, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic fw(input logic c, input logic r);
        fw_continue = c;
        fw_role = r;
        pulse(fw_ctl_write);
    endtask

    function automatic logic [13:0] vec_of(input int i);
        return 14'(2 * (i + 1));
    endfunction

    // Fire the pulse sources of a mask together; endpoint acks split between IN and OUT
    task automatic fire(input logic [11:0] m);
        logic [4:0] r;
        r = 5'($urandom);
        {timer_1024us_tick, timer_128us_tick} = m[2:1];
        ep_in_host_ack = m[7:3] & r;
        ep_out_dev_ack = m[7:3] & ~r;
        {tw_master_byte, parallel_host_port_event} = {m[11], m[10]};
        cyc(1);
        {timer_128us_tick, timer_1024us_tick, tw_master_byte, parallel_host_port_event} = '0;
        {ep_in_host_ack, ep_out_dev_ack} = '0;
    endtask

    // Let the core run until every expected vector was taken, lowest index first
    task automatic serve(input logic [11:0] m);
        int k;
        for (int i = 0; i < 12; i++)
            if (m[i])
                exp_q.push_back(vec_of(i));
        run = 1'b1;
        for (k = 0; k < 2000 && exp_q.size() != 0; k++)
            cyc(1);
        cyc(20);
        run = 1'b0;
        chk("pending after service", 16'h0000, {4'h0, pending});
        chk("entries missing", 16'h0000, 16'(exp_q.size()));
    endtask

    // Entry monitor: vector order, push and call-plus-jump latency
    always @(negedge clock)
    begin
        lat++;
        if (gie_clear === 1'b1)
        begin
            lat = 0;
            chkb("stack push", 1'b1, stack_push);
            chk("vector", exp_q.size() ? {2'h0, exp_q.pop_front()} : 16'hffff,
                {2'h0, vector_addr});
        end
        if (service_start === 1'b1)
            chk("entry latency", 16'h000f, 16'(lat));
        // Address clear and start-up abort must come as one recognition
        if (usb_addr_clear === 1'b1 && startup_abort === 1'b1)
            saw_clr = 1'b1;
    end

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_errors++;
        summarize();
    end

    initial
    begin
        logic [11:0] m;
        void'($urandom(32'h0930a642));
        {d_minus, timer_128us_tick, timer_1024us_tick, status_busrst_clear, run, saw_clr} = '0;
        {tw_rx_byte, tw_rx_first, tw_tx_byte, tw_tx_acked, tw_master_byte, tw_stop_seen} = '0;
        {tw_arb_lost, fw_ctl_write, fw_continue, fw_role, fw_ack, parallel_host_port_event} = '0;
        {ep_in_host_ack, ep_out_dev_ack, port_pins, port_enable, port_polarity} = '0;
        {d_plus, parallel_host_port_en, analog_pins, analog_polarity} = {2'h3, 8'h02, 8'h01};
        // Firmware masks both timers first, as it would before suspend
        {analog_enable, global_enable, ep_enable} = {8'h03, 8'h71, 5'h1f};
        rst_n = 1'b0;
        cyc(8);
        chkb("fetch from reset", 1'b1, fetch_from_reset);
        chk("reset vector", 16'h0000, {2'h0, vector_addr});
        rst_n = 1'b1;
        cyc(4);
        // A disabled source stays pending without a request
        fire(12'h006);
        run = 1'b1;
        cyc(40);
        chk("masked pending", 16'h0006, {4'h0, pending});
        global_enable = 8'h77;
        serve(12'h006);
        // All pulse sources at once, then random mixes
        for (int i = 0; i < 24; i++)
        begin
            m = (i == 0) ? 12'hcfe : 12'($urandom) & 12'hcfe;
            fire(m);
            chk("pending set", {4'h0, m}, {4'h0, pending});
            serve(m);
        end
        // Analog pins: one latched pin blocks the rest until it goes inactive
        analog_pins = 8'h03;
        cyc(4);
        chkb("analog rise", 1'b1, pending[9]);
        serve(12'h200);
        analog_pins = 8'h01;
        cyc(4);
        chkb("analog blocked", 1'b0, pending[9]);
        analog_pins = 8'h02;
        cyc(4);
        analog_pins = 8'h00;
        cyc(4);
        chkb("analog fall", 1'b1, pending[9]);
        serve(12'h200);
        // Port pins are silent while the parallel host port owns the vector
        // Pin 8 rises on a rising-polarity port, a real edge that must be swallowed
        {port_enable, port_polarity, port_pins} = {16'hffff, 2'h2, 16'h0108};
        cyc(5);
        chkb("port suppressed", 1'b0, pending[10]);
        parallel_host_port_en = 1'b0;
        port_pins = 16'h0200;
        cyc(5);
        chkb("port edge", 1'b1, pending[10]);
        serve(12'h400);
        port_pins = 16'h0600;
        cyc(5);
        chkb("port blocked", 1'b0, pending[10]);
        // Short SE0 is not a bus reset, a long one is
        d_plus = 1'b0;
        cyc(1100);
        d_plus = 1'b1;
        cyc(5);
        chkb("short se0", 1'b0, status_busrst);
        d_plus = 1'b0;
        cyc(1250);
        chkb("bus reset status", 1'b1, status_busrst);
        chkb("address clear", 1'b1, saw_clr);
        chkb("no irq during se0", 1'b0, pending[0]);
        d_plus = 1'b1;
        cyc(5);
        chkb("irq at se0 end", 1'b1, pending[0]);
        serve(12'h001);
        pulse(status_busrst_clear);
        chkb("status cleared", 1'b0, status_busrst);
        // Serial engine events
        fw(1'b1, 1'b1);
        pulse(tw_arb_lost);
        chkb("role after loss", 1'b0, controller_role_bit);
        chkb("arb flag", 1'b1, arbitration_lost_flag);
        chkb("no irq before stop", 1'b0, pending[11]);
        pulse(tw_stop_seen);
        chkb("irq at stop", 1'b1, pending[11]);
        serve(12'h800);
        fw(1'b1, 1'b1);
        pulse(tw_master_byte);
        chkb("busy cleared", 1'b0, continue_busy);
        fw(1'b1, 1'b0);
        chkb("stop request", 1'b1, stop_request);
        serve(12'h800);
        fw(1'b1, 1'b0);
        tw_rx_first = 1'b1;
        pulse(tw_rx_byte);
        chkb("address flag", 1'b1, addr_flag);
        chkb("rx irq", 1'b1, pending[11]);
        pulse(tw_stop_seen);
        chkb("stop after nack", 1'b0, rx_stop_flag);
        // Byte answered with the acknowledge bit set: the stop now counts
        fw_ack = 1'b1;
        fw(1'b1, 1'b0);
        pulse(tw_rx_byte);
        pulse(tw_stop_seen);
        chkb("stop flag", 1'b1, rx_stop_flag);
        fw_ack = 1'b0;
        fw(1'b1, 1'b0);
        tw_tx_acked = 1'b1;
        pulse(tw_tx_byte);
        chkb("tx ack flag", 1'b1, ack_flag);
        tw_tx_acked = 1'b0;
        pulse(tw_tx_byte);
        chkb("tx nack flag", 1'b0, ack_flag);
        serve(12'h800);
        summarize();
    end
endmodule
